// File: inc/wid_cfg.svh
// widths, field positions and reset values for the instruction decoder
`ifndef WID_CFG_SVH
`define WID_CFG_SVH
`define WID_WORD_W        16
`define WID_REG_COUNT     16
`define WID_WP_RESET      16'h0000
`define WID_PC_RESET      16'h0000
`define WID_FLAG_RESET    16'h0000
`define WID_PARITY_BIT    10
`define WID_TRAP_BIT      6
`define WID_OP_MOV        3'h6
`define WID_SERIAL_BYTE_MAX 5'h08
// register word indices on the avalon slave (byte offset divided by four)
`define WID_A_CTRL        4'h0
`define WID_A_INSTR       4'h1
`define WID_A_WP          4'h2
`define WID_A_PC          4'h3
`define WID_A_FLAGS       4'h4
`define WID_A_FMT         4'h5
`define WID_A_SRC_EA      4'h6
`define WID_A_DST_EA      4'h7
`define WID_A_RESULT      4'h8
`define WID_A_MEMWIN      4'h9
`define WID_A_MEMADDR     4'hA
`endif

// File: inc/wid_pkg.sv
// types shared by the instruction decoder files
package wid_pkg;
   typedef enum logic [3:0] {
      WID_FMT_TWO_OP   = 4'h1,
      WID_FMT_REG_SRC  = 4'h3,
      WID_FMT_SERIAL   = 4'h4,
      WID_FMT_SINGLE   = 4'h6,
      WID_FMT_JUMP     = 4'h2,
      WID_FMT_SHIFT    = 4'h5,
      WID_FMT_IMM      = 4'h8,
      WID_FMT_CTRL     = 4'h7,
      WID_FMT_REG_ONLY = 4'h9,
      WID_FMT_NONE     = 4'h0
   } wid_fmt_e;
   typedef enum logic [2:0] {
      WID_AM_DIRECT  = 3'h0,
      WID_AM_INDIR   = 3'h1,
      WID_AM_SYMBOL  = 3'h2,
      WID_AM_INDEXED = 3'h3,
      WID_AM_AUTOINC = 3'h4,
      WID_AM_NONE    = 3'h7
   } wid_am_e;
   typedef struct packed {
      wid_fmt_e   fmt;
      logic [3:0] opcode;
      logic       width_flag;
      logic [1:0] dest_mode_field;
      logic [3:0] dest_reg_field;
      logic [1:0] src_mode_field;
      logic [3:0] source_reg_field;
      logic [7:0] disp;
      logic [3:0] count;
   } wid_fields_s;
endpackage : wid_pkg

// File: verilog/wid_mem.sv
// small word memory standing for workspace and instruction store
`timescale 1ns/1ps
module wid_mem #(
   parameter int AW = 8
) (
   input  wire logic          clk,    // clock
   input  wire logic          we,     // write strobe
   input  wire logic [AW-1:0] waddr,  // write word address
   input  wire logic [15:0]   wdata,  // write data
   input  wire logic [AW-1:0] raddr,  // read word address
   output logic [15:0]        rdata   // registered read data
);
   logic [15:0] mem [0:(1<<AW)-1];
   always_ff @(posedge clk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule : wid_mem

// File: verilog/wid_decoder.sv
// instruction decoder and operand resolver with avalon register slave
//Contract
//RL1: serial transfers of up to eight bits set parity like bytes; longer keep it.
//RL2: execute instruction leaves status untouched; target instruction updates it normally.
//RL3: software trap entry sets the trap status bit.
//RL4: instructions are one to three sixteen-bit words, first word defines operation.
//RL5: first word classified into one of nine formats.
//RL6: width flag one means byte access, zero means word access.
//RL7: two-bit mode fields give five addressing modes for destination and source.
//RL8: mode decoding only in the five formats carrying mode fields; code decodes them in four: two-operand, register-source, serial, single.
//RL9: register fields are four-bit workspace register numbers 0 to 15.
//RL10: relative jumps add displacement to program counter.
//RL11: count field gives shift positions or serial bit count.
//RL12: mode 00 operand is the register itself.
//RL13: byte access to a register uses its most significant byte.
//RL14: destination fields sit above source fields in two-operand formats.
//RL15: opcode 110 in two-operand format is move.
//RL16: mode 01 reads register then accesses memory at that address.
//RL17: workspace is sixteen words with base at register 0.
//RL18: mode 11 is indirect then increments register by one or two.
//RL19: mode 10 with register zero uses next word; nonzero adds index.
//RL20: register address is workspace base plus twice register number.
`timescale 1ns/1ps
`include "wid_cfg.svh"
module wid_decoder #(
   parameter int AW = 8
) (
   input  wire logic        clk,              // 25 MHz clock
   input  wire logic        rst,              // async reset, active high
   input  wire logic [5:0]  avs_address,      // byte address
   input  wire logic        avs_read,         // read request
   input  wire logic        avs_write,        // write request
   input  wire logic [31:0] avs_writedata,    // write data
   input  wire logic [3:0]  avs_byteenable,   // byte lanes
   output logic [31:0]      avs_readdata,     // read data
   output logic             avs_waitrequest,  // stall
   output logic             busy              // decode in progress
);
   typedef enum logic [3:0] {
      S_IDLE = 4'h0, S_FETCH = 4'h1, S_DEC = 4'h2, S_SRC_REG = 4'h3,
      S_SRC_EXT = 4'h4, S_DST_REG = 4'h5, S_DST_EXT = 4'h6, S_OPND = 4'h7,
      S_DONE = 4'h8, S_WAIT = 4'h9
   } wid_state_e;

   wid_state_e  state;
   wid_state_e  ret_state;
   logic [15:0] wp, pc, flag_word, instr, src_ea, dst_ea, result, ext_ptr;
   logic [15:0] reg_val;
   logic [AW-1:0] mem_addr;
   logic        dst_phase;
   wid_pkg::wid_fields_s f;
   wid_pkg::wid_am_e src_am, dst_am;
   logic [4:0]  serial_n;
   logic [2:0]  nwords;
   logic        ack;

   // field split of first word; bit 0 is the msb in printed numbering
   function automatic wid_pkg::wid_am_e mode_of(input logic [1:0] m, input logic [3:0] r); //RL7
      case (m)
         2'h0: mode_of = wid_pkg::WID_AM_DIRECT;   //RL12
         2'h1: mode_of = wid_pkg::WID_AM_INDIR;    //RL16
         2'h2: mode_of = (r == 4'h0) ? wid_pkg::WID_AM_SYMBOL : wid_pkg::WID_AM_INDEXED; //RL19
         default: mode_of = wid_pkg::WID_AM_AUTOINC; //RL18
      endcase
   endfunction : mode_of

   function automatic logic [15:0] reg_addr(input logic [15:0] base, input logic [3:0] r);
      reg_addr = base + {11'h000, r, 1'b0}; //RL20 RL17
   endfunction : reg_addr

   // format classification by leading zeros
   wire logic [15:0] w = instr;
   wid_pkg::wid_fmt_e fmt;
   assign fmt = (w[15:14] != 2'h0) ? wid_pkg::WID_FMT_TWO_OP :
                (w[15:12] == 4'h2 && w[11:10] != 2'h3) ? wid_pkg::WID_FMT_REG_SRC :
                (w[15:11] == 5'h06) ? wid_pkg::WID_FMT_SERIAL :
                (w[15:12] == 4'h1) ? ((w[11:8] >= 4'hD) ? wid_pkg::WID_FMT_REG_SRC :
                                      wid_pkg::WID_FMT_JUMP) :
                (w[15:12] == 4'h2) ? wid_pkg::WID_FMT_REG_SRC :
                (w[15:10] == 6'h01) ? wid_pkg::WID_FMT_SINGLE :
                (w[15:11] == 5'h01) ? wid_pkg::WID_FMT_SHIFT :
                (w[15:8] == 8'h02 && w[4] == 1'b0) ? wid_pkg::WID_FMT_IMM :
                (w[15:8] == 8'h03) ? wid_pkg::WID_FMT_CTRL :
                (w[15:8] == 8'h02) ? wid_pkg::WID_FMT_REG_ONLY :
                wid_pkg::WID_FMT_NONE; //RL5
   wire logic has_src = (fmt == wid_pkg::WID_FMT_TWO_OP) || (fmt == wid_pkg::WID_FMT_REG_SRC)
                        || (fmt == wid_pkg::WID_FMT_SERIAL) || (fmt == wid_pkg::WID_FMT_SINGLE);
   wire logic has_dst = (fmt == wid_pkg::WID_FMT_TWO_OP); //RL8
   wire logic two_op_byte = (fmt == wid_pkg::WID_FMT_TWO_OP) && w[15:13] != 3'h1;
   assign f.fmt = fmt;
   assign f.opcode = {1'b0, w[15:13]};
   assign f.width_flag = two_op_byte ? w[12] : 1'b0; //RL6
   assign f.dest_mode_field = has_dst ? w[11:10] : 2'h0; //RL14
   assign f.dest_reg_field = (fmt == wid_pkg::WID_FMT_REG_SRC || has_dst) ? w[9:6] : 4'h0; //RL9
   assign f.src_mode_field = has_src ? w[5:4] : 2'h0;
   assign f.source_reg_field = w[3:0];
   assign f.disp = w[7:0];
   assign f.count = (fmt == wid_pkg::WID_FMT_SHIFT) ? w[7:4] : w[9:6]; //RL11
   assign src_am = has_src ? mode_of(f.src_mode_field, f.source_reg_field) : wid_pkg::WID_AM_NONE;
   assign dst_am = has_dst ? mode_of(f.dest_mode_field, f.dest_reg_field) : wid_pkg::WID_AM_NONE;
   wire logic is_mov = has_dst && (w[15:13] == `WID_OP_MOV); //RL15
   wire logic is_serial = (fmt == wid_pkg::WID_FMT_SERIAL);
   wire logic is_exec = (w[15:6] == 10'h012); // execute-target opcode
   // trap entry words sit just below the serial group
   wire logic is_trap = (w[15:10] == 6'h0B);
   assign serial_n = (f.count == 4'h0) ? 5'h10 : {1'b0, f.count};
   wire logic serial_xfer = is_serial && (w[15:10] == 6'h0C || w[15:10] == 6'h0D);
   wire logic byte_wide = two_op_byte ? w[12]
                        : (serial_xfer && serial_n <= `WID_SERIAL_BYTE_MAX);
   wire logic [15:0] inc_amt = byte_wide ? 16'h0001 : 16'h0002; //RL18
   wire logic [15:0] jmp_pc = pc + {{7{f.disp[7]}}, f.disp, 1'b0}; //RL10
   wire logic [15:0] rdw;
   wire logic par = ^rdw[15:8]; //RL13
   wire logic cur_ph = dst_phase;
   wid_pkg::wid_am_e cur_am;
   assign cur_am = cur_ph ? dst_am : src_am;
   wire logic [3:0] cur_r = cur_ph ? f.dest_reg_field : f.source_reg_field;
   wire logic [15:0] cur_reg_a = reg_addr(wp, cur_r); //RL20

   // bus decode
   wire logic        req = avs_read | avs_write;
   wire logic [3:0]  idx = avs_address[5:2];
   wire logic        wr_en = avs_write & ack & avs_byteenable[0] & avs_byteenable[1];
   wire logic        bus_mem_we = wr_en && idx == `WID_A_MEMWIN && state == S_IDLE;
   wire logic        go = wr_en && idx == `WID_A_CTRL && avs_writedata[0] && state == S_IDLE;
   wire logic [31:0] rd_mux =
      (idx == `WID_A_CTRL)    ? {31'h0, busy} :
      (idx == `WID_A_INSTR)   ? {16'h0, instr} :
      (idx == `WID_A_WP)      ? {16'h0, wp} :
      (idx == `WID_A_PC)      ? {16'h0, pc} :
      (idx == `WID_A_FLAGS)   ? {16'h0, flag_word} :
      (idx == `WID_A_FMT)     ? {9'h000, nwords, dst_am, src_am, f.width_flag, is_mov,
                                 f.count, f.src_mode_field, f.dest_mode_field, f.fmt} :
      (idx == `WID_A_SRC_EA)  ? {16'h0, src_ea} :
      (idx == `WID_A_DST_EA)  ? {16'h0, dst_ea} :
      (idx == `WID_A_RESULT)  ? {16'h0, result} :
      (idx == `WID_A_MEMWIN)  ? {16'h0, rdw} :
      (idx == `WID_A_MEMADDR) ? {16'h0, ext_ptr} : 32'h0;

   wire logic [AW-1:0] mem_waddr = bus_mem_we ? ext_ptr[AW:1] : mem_addr;
   logic        core_we;
   logic [15:0] core_wd;
   wid_mem #(.AW(AW)) u_mem (
      .clk   (clk),
      .we    (bus_mem_we | core_we),
      .waddr (mem_waddr),
      .wdata (bus_mem_we ? avs_writedata[15:0] : core_wd),
      .raddr (state == S_IDLE ? ext_ptr[AW:1] : mem_addr),
      .rdata (rdw)
   );

   // one wait cycle so memory window read data are valid
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst) ack <= 1'b0;
      else ack <= req & ~ack;
   end
   assign avs_waitrequest = req & ~ack;
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst) avs_readdata <= 32'h0;
      else if (req & ~ack) avs_readdata <= rd_mux;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state <= S_IDLE; ret_state <= S_IDLE; wp <= `WID_WP_RESET; pc <= `WID_PC_RESET;
         flag_word <= `WID_FLAG_RESET; instr <= 16'h0; src_ea <= 16'h0; dst_ea <= 16'h0;
         result <= 16'h0; ext_ptr <= 16'h0; mem_addr <= '0; dst_phase <= 1'b0;
         busy <= 1'b0; nwords <= 3'h0; core_we <= 1'b0; core_wd <= 16'h0; reg_val <= 16'h0;
      end
      else
      begin
         core_we <= 1'b0;
         if (wr_en && state == S_IDLE)
         begin
            if (idx == `WID_A_WP) wp <= avs_writedata[15:0];
            if (idx == `WID_A_PC) pc <= avs_writedata[15:0];
            if (idx == `WID_A_FLAGS) flag_word <= avs_writedata[15:0];
            if (idx == `WID_A_MEMADDR) ext_ptr <= avs_writedata[15:0];
            if (idx == `WID_A_MEMWIN) ext_ptr <= ext_ptr + 16'h0002;
         end
         case (state)
            S_IDLE:
            begin
               if (go)
               begin
                  busy <= 1'b1; mem_addr <= pc[AW:1]; state <= S_WAIT; ret_state <= S_FETCH;
               end
            end
            S_WAIT: state <= ret_state;
            S_FETCH:
            begin
               instr <= rdw; pc <= pc + 16'h0002; nwords <= 3'h1; dst_phase <= 1'b0; //RL4
               state <= S_DEC;
            end
            S_DEC:
            begin
               if (is_trap) flag_word[`WID_TRAP_BIT] <= 1'b1; //RL3
               if (fmt == wid_pkg::WID_FMT_JUMP && !is_exec) pc <= jmp_pc; //RL10
               if (serial_xfer && serial_n <= `WID_SERIAL_BYTE_MAX)
                  flag_word[`WID_PARITY_BIT] <= 1'b0; //RL1
               // execute-target keeps status as is //RL2
               state <= has_src ? S_SRC_REG : S_DONE;
            end
            S_SRC_REG, S_DST_REG:
            begin
               ext_ptr <= ext_ptr;
               // both symbolic forms first fetch the address word after the instruction
               if (cur_am == wid_pkg::WID_AM_SYMBOL || cur_am == wid_pkg::WID_AM_INDEXED)
                  mem_addr <= pc[AW:1]; //RL19
               else
                  mem_addr <= cur_reg_a[AW:1]; //RL17
               ret_state <= (state == S_SRC_REG) ? S_SRC_EXT : S_DST_EXT;
               state <= S_WAIT;
            end
            S_SRC_EXT, S_DST_EXT:
            begin
               reg_val <= rdw;
               case (cur_am)
                  wid_pkg::WID_AM_DIRECT: result <= reg_addr(wp, cur_r); //RL12
                  wid_pkg::WID_AM_INDIR: result <= rdw; //RL16
                  wid_pkg::WID_AM_AUTOINC:
                  begin
                     result <= rdw;
                     core_wd <= rdw + inc_amt; core_we <= 1'b1; //RL18
                  end
                  wid_pkg::WID_AM_SYMBOL:
                  begin
                     result <= rdw; pc <= pc + 16'h0002; nwords <= nwords + 3'h1; //RL19
                  end
                  default:
                  begin
                     result <= rdw; pc <= pc + 16'h0002; nwords <= nwords + 3'h1;
                     mem_addr <= cur_reg_a[AW:1]; //RL19
                  end
               endcase
               // every phase passes the operand stage so its address gets stored
               if (cur_am == wid_pkg::WID_AM_INDEXED)
               begin
                  state     <= S_WAIT;
                  ret_state <= S_OPND;
               end
               else
               begin
                  state <= S_OPND;
               end
            end
            S_OPND:
            begin
               if (cur_am == wid_pkg::WID_AM_INDEXED) result <= result + rdw; //RL19
               if (!cur_ph) src_ea <= (cur_am == wid_pkg::WID_AM_INDEXED) ? result + rdw : result;
               else dst_ea <= (cur_am == wid_pkg::WID_AM_INDEXED) ? result + rdw : result;
               if (!cur_ph && has_dst) begin dst_phase <= 1'b1; state <= S_DST_REG; end
               else state <= S_DONE;
            end
            S_DONE:
            begin
               if (!has_dst && cur_am != wid_pkg::WID_AM_NONE && !cur_ph) src_ea <= result;
               if (serial_xfer && serial_n <= `WID_SERIAL_BYTE_MAX)
                  flag_word[`WID_PARITY_BIT] <= par; //RL1
               busy <= 1'b0; state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule : wid_decoder

// File: verification/wid_decoder_checker.sv
// bus protocol and decode timing checker for the instruction decoder
`timescale 1ns/1ps
module wid_decoder_checker #(
   parameter int AW = 8
) (
   input logic        clk,             // clock
   input logic        rst,             // async reset
   input logic [5:0]  avs_address,     // byte address
   input logic        avs_read,        // read request
   input logic        avs_write,       // write request
   input logic [31:0] avs_writedata,   // write data
   input logic [3:0]  avs_byteenable,  // byte lanes
   input logic [31:0] avs_readdata,    // read data
   input logic        avs_waitrequest, // stall
   input logic        busy             // decode running
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wire req = avs_read | avs_write;
   wire done = req & ~avs_waitrequest;
   wire start = avs_write & done & (avs_address[5:2] == 4'h0) & avs_writedata[0]
      & (avs_byteenable[1:0] == 2'h3) & ~busy;
   wait_first_a: assert property (req && !$past(req) |-> avs_waitrequest)
      else $error("request not stalled in its first cycle");
   answer_next_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("stall lasted beyond one cycle");
   idle_nowait_a: assert property (!req |-> !avs_waitrequest)
      else $error("stall raised without a request");
   rdata_hold_a: assert property (!req && !$past(req) |-> $stable(avs_readdata))
      else $error("read data moved while idle");
   unmapped_zero_a: assert property (avs_read && done && avs_address[5:2] > 4'hA
      |-> avs_readdata == 32'h00000000)
      else $error("unmapped offset read nonzero");
   upper_zero_a: assert property (avs_read && done && avs_address[5:2] != 4'h5
      |-> avs_readdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   fmt_pad_a: assert property (avs_read && done && avs_address[5:2] == 4'h5
      |-> avs_readdata[31:23] == 9'h000)
      else $error("decoded field word padding not zero");
   busy_starts_a: assert property (start |-> ##[1:3] busy)
      else $error("start did not raise busy");
   busy_ends_a: assert property ($rose(busy) |-> ##[1:200] !busy)
      else $error("decode never finished");
   cover property (start);
   cover property (avs_read && done);
   cover property ($fell(busy));
endmodule : wid_decoder_checker

bind wid_decoder wid_decoder_checker #(.AW(AW)) u_chk (.clk(clk), .rst(rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busy(busy));

// File: verification/wid_mem_model.sv
// reference image of the workspace and program memory
`timescale 1ns/1ps
module wid_mem_model;
   logic [15:0] mem [256];
   task automatic put(input logic [15:0] a, input logic [15:0] d);
      mem[a[8:1]] = d;
   endtask : put
   function automatic logic [15:0] get(input logic [15:0] a);
      return mem[a[8:1]];
   endfunction : get
endmodule : wid_mem_model

// File: verification/wid_decoder_bench.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
`include "wid_cfg.svh"
module wid_decoder_bench;
   logic        clk, rst, avs_read, avs_write, avs_waitrequest, busy;
   logic [5:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0]  avs_byteenable;
   logic [15:0] q;
   int          n_fail, compares;
   localparam logic [15:0] WP = 16'h0020;
   localparam logic [15:0] PC = 16'h0040;
   wid_mem_model mm();
   wid_decoder #(.AW(8)) uut (.clk(clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .busy(busy));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic give_verdict;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // holds the request until waitrequest is sampled low, then idles one cycle
   task automatic bus(input logic w, input logic [3:0] i, input logic [15:0] d);
      int n;
      n = 0;
      avs_address   <= {i, 2'h0};
      avs_writedata <= {16'h0000, d};
      avs_write     <= w;
      avs_read      <= ~w;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata[15:0];
      if (n >= 50)
         n_fail++;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic rdc(input logic [3:0] i, input logic [15:0] e, input string nm);
      bus(1'b0, i, 16'h0000);
      chk(nm, e, q);
   endtask : rdc
   task automatic memw(input logic [15:0] a, input logic [15:0] d);
      bus(1'b1, 4'hA, a);
      bus(1'b1, 4'h9, d);
      mm.put(a, d);
   endtask : memw
   task automatic memc(input logic [15:0] a, input string nm);
      bus(1'b1, 4'hA, a);
      rdc(4'h9, mm.get(a), nm);
   endtask : memc
   task automatic run(input logic [15:0] ins);
      memw(PC, ins);
      bus(1'b1, 4'h2, WP);
      bus(1'b1, 4'h3, PC);
      bus(1'b1, 4'h1, ins);
      bus(1'b1, 4'h0, 16'h0001);
      q = 16'h0001;
      for (int k = 0; k < 100 && q[0] !== 1'b0; k++)
         bus(1'b0, 4'h0, 16'h0000);
      chk("busy", 16'h0000, {15'h0000, q[0]});
   endtask : run
   task automatic t_reset;
      rdc(4'h2, 16'h0000, "wp reset");
      rdc(4'h3, 16'h0000, "pc reset");
      rdc(4'h4, 16'h0000, "st reset");
      rdc(4'hF, 16'h0000, "unmapped");
      bus(1'b1, 4'h2, WP);
      rdc(4'h2, WP, "wp");
      $display("reset test done");
   endtask : t_reset
   task automatic t_modes;
      run(16'hC101);
      rdc(4'h6, WP + 16'h0002, "direct src");
      rdc(4'h7, WP + 16'h0008, "direct dst");
      bus(1'b0, 4'h5, 16'h0000);
      chk("move format", {4'h1, 8'h00, wid_pkg::WID_FMT_TWO_OP}, q & 16'h300F);
      run(16'hD101);
      rdc(4'h7, WP + 16'h0008, "byte reg dst");
      bus(1'b0, 4'h5, 16'h0000);
      chk("byte format", {4'h3, 8'h00, wid_pkg::WID_FMT_TWO_OP}, q & 16'h300F);
      memw(WP + 16'h0008, 16'h0080);
      memw(WP + 16'h0002, 16'h0090);
      run(16'hC501);
      rdc(4'h7, 16'h0080, "indirect dst");
      run(16'hC111);
      rdc(4'h6, 16'h0090, "indirect src");
      $display("mode test done");
   endtask : t_modes
   task automatic t_autoinc;
      run(16'hCD01);
      rdc(4'h7, 16'h0080, "autoinc dst");
      mm.put(WP + 16'h0008, 16'h0082);
      memc(WP + 16'h0008, "word step");
      run(16'hDD01);
      rdc(4'h7, 16'h0082, "byte autoinc dst");
      mm.put(WP + 16'h0008, 16'h0083);
      memc(WP + 16'h0008, "byte step");
      $display("autoinc test done");
   endtask : t_autoinc
   task automatic t_symbol;
      memw(PC + 16'h0002, 16'h00A0);
      run(16'hC801);
      rdc(4'h7, 16'h00A0, "symbolic");
      memw(WP + 16'h0002, 16'h0004);
      run(16'hC841);
      rdc(4'h7, 16'h00A4, "indexed");
      $display("symbolic test done");
   endtask : t_symbol
   task automatic t_status;
      memw(WP + 16'h0004, 16'h0700);
      bus(1'b1, 4'h4, 16'h0000);
      run(16'h30C2);
      bus(1'b0, 4'h4, 16'h0000);
      chk("short parity", 16'h0001, {15'h0000, q[`WID_PARITY_BIT]});
      bus(1'b1, 4'h4, 16'h0000);
      run(16'h3242);
      bus(1'b0, 4'h4, 16'h0000);
      chk("long parity", 16'h0000, {15'h0000, q[`WID_PARITY_BIT]});
      bus(1'b1, 4'h4, 16'h0000);
      run(16'h2C42);
      bus(1'b0, 4'h4, 16'h0000);
      chk("trap bit", 16'h0001, {15'h0000, q[`WID_TRAP_BIT]});
      bus(1'b1, 4'h4, 16'h0440);
      run(16'h0482);
      rdc(4'h4, 16'h0440, "execute keeps flags");
      run(16'h1003);
      rdc(4'h3, PC + 16'h0008, "jump target");
      run(16'h0A52);
      bus(1'b0, 4'h5, 16'h0000);
      chk("shift count", {4'h0, 4'h5, 4'h0, wid_pkg::WID_FMT_SHIFT}, q & 16'h0F0F);
      $display("status test done");
   endtask : t_status
   initial
   begin
      rst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 6'h00;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hF;
      n_fail = 0;
      compares = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_modes();
      t_autoinc();
      t_symbol();
      t_status();
      give_verdict();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      give_verdict();
   end
endmodule : wid_decoder_bench
